//--- rtl/seq_b_step_ctrl.sv
`include "seq_step_consts.svh"

module seq_b_step_ctrl #(
  parameter int NUM_STEPS = 2
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  input  wire seq_step_pkg::reg_req_t req,
  output logic [15:0]                 rdata,
  output logic                        rd_valid,
  input  wire logic                   seq_start,
  input  wire logic                   conv_done,
  output logic                        conv_start,
  output seq_step_pkg::conv_setting_t conv_setting,
  output logic                        seq_busy,
  output logic                        seq_done
);
  import seq_step_pkg::*;

  localparam int IDX_W = (NUM_STEPS > 1) ? $clog2(NUM_STEPS) : 1;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_STEPS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic       rst_meta_n; // First stage
  logic       rst_sync_n; // Reset used by the design
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Address hit for step number idx
  function automatic logic step_hit(input logic [7:0] addr, input int idx);
    step_hit = (addr == 8'(`STEP_ELEVEN_ADDR + idx));
  endfunction

  // Gain code to factor; both upper codes give four
  function automatic logic [2:0] gain_factor(input logic [1:0] code);
    case (code)
      `GAIN_CODE_ONE: gain_factor = `GAIN_FACTOR_ONE;
      `GAIN_CODE_TWO: gain_factor = `GAIN_FACTOR_TWO;
      default:        gain_factor = `GAIN_FACTOR_FOUR;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Step registers, one per sequencer step
  step_cfg_t cfgs [NUM_STEPS]; // Stored step words
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STEPS; gi++)
    begin : g_step
      step_config_reg #(
        .RESET_VALUE (16'(`STEP_ELEVEN_RESET + gi)),
        .REG_ADDR    (8'(`STEP_ELEVEN_ADDR + gi))
      ) u_reg (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .ce    (ce),
        .req   (req),
        .cfg   (cfgs[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read path, answered one cycle after the strobe
  logic [15:0] next_rdata;    // Next read data
  logic        next_rd_valid; // Next read valid

  // Select the addressed word; unmapped reads return zero
  always_comb
  begin
    next_rdata    = rdata;
    next_rd_valid = req.rd;
    if (req.rd)
    begin
      next_rdata = `UNMAPPED_READ;
      for (int i = 0; i < NUM_STEPS; i++)
      begin
        if (step_hit(req.addr, i))
        begin
          next_rdata = 16'(cfgs[i]) & `CFG_WRITE_MASK;
        end
      end
    end
  end

  // Read registers
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rdata    <= 16'h0000;
      rd_valid <= 1'b0;
    end
    else if (ce)
    begin
      rdata    <= next_rdata;
      rd_valid <= next_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer walking the steps in order
  seq_state_t    state;             // Current state
  seq_state_t    next_state;        // Next state
  logic [IDX_W-1:0] idx;            // Step being handled
  logic [IDX_W-1:0] next_idx;       // Next step
  logic          next_conv_start;   // Next conversion pulse
  conv_setting_t next_conv_setting; // Next applied setting
  logic          next_seq_done;     // Next end-of-pass pulse
  step_cfg_t     cur;               // Word of the current step

  assign cur      = cfgs[idx];
  assign seq_busy = (state != SEQ_IDLE);

  // Next state and outputs
  always_comb
  begin
    next_state        = state;
    next_idx          = idx;
    next_conv_start   = 1'b0;
    next_conv_setting = conv_setting;
    next_seq_done     = 1'b0;
    case (state)
      SEQ_IDLE:
      begin
        // Start a pass at the first step
        if (seq_start)
        begin
          next_idx   = '0;
          next_state = SEQ_PICK;
        end
      end
      SEQ_PICK:
      begin
        if (cur.enable)
        begin
          // Apply this step's gain and inputs
          next_conv_start              = 1'b1;
          next_conv_setting.gain_factor = gain_factor(cur.gain);
          next_conv_setting.pos_select  = cur.pos_select;
          next_conv_setting.auto_neg    = cur.pos_select[`POS_INTERNAL_BIT];
          // Negative choice only counts for external positive inputs
          next_conv_setting.neg_select  = cur.pos_select[`POS_INTERNAL_BIT] ? 1'b0
                                          : cur.neg_select;
          next_state = SEQ_CONVERT;
        end
        else if (idx == LAST_IDX)
        begin
          // Disabled last step ends the pass
          next_seq_done = 1'b1;
          next_state    = SEQ_IDLE;
        end
        else
        begin
          // Pass over a disabled step
          next_idx = idx + 1'b1;
        end
      end
      SEQ_CONVERT:
      begin
        // Wait for the converter, then move on
        if (conv_done)
        begin
          if (idx == LAST_IDX)
          begin
            next_seq_done = 1'b1;
            next_state    = SEQ_IDLE;
          end
          else
          begin
            next_idx   = idx + 1'b1;
            next_state = SEQ_PICK;
          end
        end
      end
      default:
      begin
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state        <= SEQ_IDLE;
      idx          <= '0;
      conv_start   <= 1'b0;
      conv_setting <= '0;
      seq_done     <= 1'b0;
    end
    else if (ce)
    begin
      state        <= next_state;
      idx          <= next_idx;
      conv_start   <= next_conv_start;
      conv_setting <= next_conv_setting;
      seq_done     <= next_seq_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // A write to step eleven lands its enable bit
  sequence s_wr_eleven;
    ce && req.wr && step_hit(req.addr, 0);
  endsequence

  property p_write_enable;
    @(posedge clk) disable iff (!rst_sync_n)
    s_wr_eleven |=> (cfgs[0].enable == $past(req.wdata[15]));
  endproperty
  a_write_enable: assert property (p_write_enable)
    else $error("step enable not stored");

  property p_gain_factor;
    @(posedge clk) disable iff (!rst_sync_n)
    (ce && state == SEQ_PICK && cur.enable) |=>
      (conv_setting.gain_factor == (($past(cur.gain) == 2'h0) ? 3'h1 :
                                    ($past(cur.gain) == 2'h1) ? 3'h2 : 3'h4));
  endproperty
  a_gain_factor: assert property (p_gain_factor)
    else $error("wrong gain applied");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_sync_n)
    rd_valid |-> ((rdata & ~`CFG_WRITE_MASK) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_neg_applied;
    @(posedge clk) disable iff (!rst_sync_n)
    (ce && state == SEQ_PICK && cur.enable && !cur.pos_select[`POS_INTERNAL_BIT]) |=>
      (conv_setting.neg_select == $past(cur.neg_select)) && !conv_setting.auto_neg;
  endproperty
  a_neg_applied: assert property (p_neg_applied)
    else $error("negative select not applied");

  property p_pos_applied;
    @(posedge clk) disable iff (!rst_sync_n)
    (ce && state == SEQ_PICK && cur.enable) |=>
      conv_start && (conv_setting.pos_select == $past(cur.pos_select));
  endproperty
  a_pos_applied: assert property (p_pos_applied)
    else $error("positive select not applied");

  property p_auto_neg;
    @(posedge clk) disable iff (!rst_sync_n)
    (conv_start && conv_setting.pos_select[`POS_INTERNAL_BIT]) |->
      (conv_setting.auto_neg && !conv_setting.neg_select);
  endproperty
  a_auto_neg: assert property (p_auto_neg)
    else $error("internal source without automatic negative");

  property p_reset_twelve;
    @(posedge clk) disable iff (!rst_sync_n)
    $rose(rst_sync_n) |-> (16'(cfgs[1]) == `STEP_TWELVE_RESET);
  endproperty
  a_reset_twelve: assert property (p_reset_twelve)
    else $error("step twelve reset value wrong");

  property p_reset_eleven;
    @(posedge clk) disable iff (!rst_sync_n)
    $rose(rst_sync_n) |-> (16'(cfgs[0]) == `STEP_ELEVEN_RESET);
  endproperty
  a_reset_eleven: assert property (p_reset_eleven)
    else $error("step eleven reset value wrong");

  // Disabled step: no conversion, move on
  sequence s_skip;
    ce && state == SEQ_PICK && !cur.enable;
  endsequence

  property p_skip_disabled;
    @(posedge clk) disable iff (!rst_sync_n)
    s_skip |=> !conv_start;
  endproperty
  a_skip_disabled: assert property (p_skip_disabled)
    else $error("disabled step converted");

endmodule

//--- common/seq_step_consts.svh
// Functional notes
// - Bit 15 enables or disables the step
// - Gain field: 00=1, 01=2, 10/11=4
// - Bits 12:5 read-only, always read zero
// - Negative select: 0 ground, 1 input seven
// - Positive codes 0-7 pick inputs zero-seven
// - Positive codes 1000 upward pick internal sources
// - Auto-negative codes ignore the negative select
// - Step twelve register at DCh, resets 000Ch
// - Step eleven register at DBh, resets 000Bh
`ifndef SEQ_STEP_CONSTS_SVH
`define SEQ_STEP_CONSTS_SVH

// Register addresses
`define STEP_ELEVEN_ADDR    8'hdb
`define STEP_TWELVE_ADDR    8'hdc

// Reset values
`define STEP_ELEVEN_RESET   16'h000b
`define STEP_TWELVE_RESET   16'h000c

// Writable bits: enable, gain, negative and positive select
`define CFG_WRITE_MASK      16'he01f

// Answer to an unmapped read
`define UNMAPPED_READ       16'h0000

// Gain field codes and factors
`define GAIN_CODE_ONE       2'h0
`define GAIN_CODE_TWO       2'h1
`define GAIN_FACTOR_ONE     3'h1
`define GAIN_FACTOR_TWO     3'h2
`define GAIN_FACTOR_FOUR    3'h4

// Positive select bit that marks internal sources
`define POS_INTERNAL_BIT    3

`endif

//--- common/seq_step_pkg.sv
package seq_step_pkg;

  // One step configuration word
  typedef struct packed {
    logic       enable;     // Step enable
    logic [1:0] gain;       // Gain code
    logic [7:0] unused;     // Always zero
    logic       neg_select; // Negative input choice
    logic [3:0] pos_select; // Positive input choice
  } step_cfg_t;

  // Register access request
  typedef struct packed {
    logic [7:0]  addr;  // Register address
    logic [15:0] wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } reg_req_t;

  // Setting applied to the converter
  typedef struct packed {
    logic [2:0] gain_factor; // 1, 2 or 4
    logic       auto_neg;    // Negative input chosen internally
    logic       neg_select;  // Negative choice when not automatic
    logic [3:0] pos_select;  // Positive input code
  } conv_setting_t;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_PICK    = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_t;

endpackage

//--- rtl/step_config_reg.sv
`include "seq_step_consts.svh"

module step_config_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [7:0]  REG_ADDR    = 8'h00
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire seq_step_pkg::reg_req_t req,
  output seq_step_pkg::step_cfg_t     cfg
);
  import seq_step_pkg::*;

  step_cfg_t next_cfg; // Value for the next edge

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; reserved bits are never stored
  always_comb
  begin
    next_cfg = cfg;
    if (req.wr && (req.addr == REG_ADDR))
    begin
      next_cfg = step_cfg_t'(req.wdata & `CFG_WRITE_MASK);
    end
  end

  // Storage, reset to the step's own value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= step_cfg_t'(RESET_VALUE);
    end
    else if (ce)
    begin
      cfg <= next_cfg;
    end
  end

endmodule

//--- tb/adc_b_sequencer_step_config_tb.sv
module adc_b_sequencer_step_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import seq_step_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic          clk;          // 10 MHz clock
  logic          resetn;       // Asynchronous reset, active low
  logic          ce;           // Clock enable, high except during the freeze test
  reg_req_t      req;          // Register request
  logic [15:0]   rdata;        // Read answer
  logic          rd_valid;     // Read answer valid
  logic          seq_start;    // Start of a pass
  logic          conv_done;    // Converter finished
  logic          conv_start;   // Conversion request
  conv_setting_t conv_setting; // Applied setting
  logic          seq_busy;     // Pass running
  logic          seq_done;     // Pass finished
  int            fails;        // Mismatches seen
  int            check_count;  // Comparisons made

  seq_b_step_ctrl dut (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .req          (req),
    .rdata        (rdata),
    .rd_valid     (rd_valid),
    .seq_start    (seq_start),
    .conv_done    (conv_done),
    .conv_start   (conv_start),
    .conv_setting (conv_setting),
    .seq_busy     (seq_busy),
    .seq_done     (seq_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #2000000;
    fails++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write strobe, lowered on the following falling edge
  task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
    @(negedge clk);
    req.addr = addr;
    req.wdata = data;
    req.wr = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // One read strobe, then a bounded wait for the answer
  task automatic reg_read(input logic [7:0] addr, output logic [15:0] data);
    int k;
    @(negedge clk);
    req.addr = addr;
    req.rd = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(negedge clk);
    check(16'(rd_valid), 16'h0001);
    data = rdata;
  endtask

  // One sequencer pass, answering every conversion request
  task automatic seq_run(output int n, output conv_setting_t last);
    int k;
    n = 0;
    last = '0;
    @(negedge clk);
    seq_start = 1'b1;
    @(negedge clk);
    seq_start = 1'b0;
    check(16'(seq_busy), 16'h0001);
    for (k = 0; k < 30 && seq_done !== 1'b1; k++)
    begin
      // Conversion request stands one cycle, so capture it now
      if (conv_start === 1'b1)
      begin
        n++;
        last = conv_setting;
        @(negedge clk);
        conv_done = 1'b1;
      end
      @(negedge clk);
      conv_done = 1'b0;
    end
    check(16'(seq_done), 16'h0001);
    check(16'(seq_busy), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Reset held eight cycles, then time for the internal release
  task automatic apply_reset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic test_reset();
    logic [15:0] d;
    reg_read(8'hdb, d);
    check(d, 16'h000b);
    reg_read(8'hdc, d);
    check(d, 16'h000c);
    reg_read(8'h00, d);
    check(d, 16'h0000);
    $display("test reset values done");
  endtask

  // Clock enable low: writes and starts are not taken
  task automatic test_freeze();
    logic [15:0] d;
    @(negedge clk);
    ce = 1'b0;
    reg_write(8'hdc, 16'h8001);
    seq_start = 1'b1;
    @(negedge clk);
    seq_start = 1'b0;
    check(16'(seq_busy), 16'h0000);
    ce = 1'b1;
    reg_read(8'hdc, d);
    check(d, 16'h000c);
    $display("test clock enable done");
  endtask

  // Unused bits never stick; unmapped writes change nothing
  task automatic test_fields();
    logic [15:0] d;
    reg_write(8'hdb, 16'hffff);
    reg_write(8'hdd, 16'hffff);
    reg_read(8'hdb, d);
    check(d, 16'he01f);
    reg_read(8'hdc, d);
    check(d, 16'h000c);
    $display("test field access done");
  endtask

  // Every positive code and every gain code on step eleven
  task automatic test_codes();
    int            n;
    conv_setting_t s;
    logic [3:0]    p;
    logic [1:0]    g;
    for (int i = 0; i < 16; i++)
    begin
      p = 4'(i);
      g = 2'(i);
      reg_write(8'hdb, {1'b1, g, 8'h00, 1'b1, p});
      seq_run(n, s);
      check(16'(n), 16'h0001);
      check(16'(s.gain_factor), (g == 2'h0) ? 16'h1 : (g == 2'h1) ? 16'h2 : 16'h4);
      check(16'(s.pos_select), 16'(p));
      check(16'(s.auto_neg), 16'(p[3]));
      check(16'(s.neg_select), p[3] ? 16'h0 : 16'h1);
    end
    $display("test input codes done");
  endtask

  // Disabled steps are passed over
  task automatic test_skip();
    int            n;
    conv_setting_t s;
    reg_write(8'hdb, 16'h0005);
    reg_write(8'hdc, 16'ha003);
    seq_run(n, s);
    check(16'(n), 16'h0001);
    check(16'(s.gain_factor), 16'h2);
    check(16'(s.pos_select), 16'h3);
    check(16'(s.neg_select), 16'h0);
    reg_write(8'hdc, 16'h0003);
    seq_run(n, s);
    check(16'(n), 16'h0000);
    $display("test step skip done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    check_count = 0;
    resetn = 1'b0;
    ce = 1'b1;
    req = '0;
    seq_start = 1'b0;
    conv_done = 1'b0;
    apply_reset();
    test_reset();
    test_freeze();
    test_fields();
    test_codes();
    // Second reset in mid-run brings the reset values back
    apply_reset();
    test_reset();
    test_skip();
    complete_run();
  end
endmodule
